// ===== design/fscr_apb_port.sv
`timescale 1ns/10ps
`include "fscr_cfg.svh"

module fscr_apb_port #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              reset,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // Register side
    output logic                   reg_wr,
    output logic                   reg_addr_ok,
    output logic [5:0]             reg_idx,
    output logic [7:0]             reg_wdata,
    input  wire logic [7:0]        reg_rdata,
    input  wire logic              reg_hit
);

    fscr_pkg::fscr_apb_state_t q;
    fscr_pkg::fscr_apb_state_t d;
    logic                      access;

    ////////////////////////////////////////////////////////////////////////////
    // Decode, zero wait states
    assign access      = psel & penable;
    assign reg_idx     = paddr[7:2];
    assign reg_addr_ok = (paddr[1:0] == 2'h0) && ((paddr >> 8) == '0);
    assign reg_wdata   = pwdata[7:0];
    assign reg_wr      = access & pwrite & reg_hit;
    assign pready      = access;
    assign pslverr     = access & ~reg_hit;
    assign prdata      = q.prdata;

    ////////////////////////////////////////////////////////////////////////////
    // Read data captured in the setup cycle
    always_comb begin
        d = q;
        if (psel && !penable) begin
            d.prdata = (reg_hit && !pwrite) ? {24'h000000, reg_rdata} : 32'h00000000;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    answer_now_a: assert property (psel && !penable |=> !penable || pready)
        else $error("access phase not answered at once");
    unmapped_err_a: assert property (access && !reg_hit |-> pslverr && !reg_wr)
        else $error("unmapped access not refused");

endmodule : fscr_apb_port

// ===== design/fscr_regs.sv
// Operation
// (R1) Ten-bit vertical scroll offset, split over two bytes
// (R2) Five-bit line spacing added between text rows
// (R3) Ten-bit horizontal text cursor, low and high
// (R4) Nine-bit vertical text cursor, low and high
// (R5) Size field picks 16, 24 or 32 pixel glyph height
// (R6) Six-bit extra pixel columns between characters
// (R7) Three-bit external font memory type, five legal
// (R8) Three-bit character coding for font memory decode
// (R9) Style variant for ASCII and Latin codings
// (R10) Host keeps size or setup clear per source
`timescale 1ns/10ps
`include "fscr_cfg.svh"

module fscr_regs #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    reset,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [ADDR_W-1:0]       paddr,
    input  wire logic [31:0]             pwdata,
    output logic                         pready,
    output logic [31:0]                  prdata,
    output logic                         pslverr,
    // Glyph source from font control
    input  wire logic                    ext_glyph_rom_sel,
    // Display scan
    output logic [9:0]                   vscroll_offset,
    output logic                         vscroll_update,
    // Text renderer
    output logic [4:0]                   text_line_spacing,
    output logic [9:0]                   text_cursor_x,
    output logic [8:0]                   text_cursor_y,
    output logic                         cursor_update,
    output fscr_pkg::fscr_size_t         glyph_size,
    output logic [5:0]                   glyph_height,
    output logic [5:0]                   char_gap,
    output logic [5:0]                   row_pitch,
    output logic [6:0]                   col_pitch,
    // Font memory fetch
    output fscr_pkg::fscr_rom_type_t     font_mem_type,
    output logic                         font_mem_type_ok,
    output fscr_pkg::fscr_coding_t       font_coding,
    output fscr_pkg::fscr_style_t        font_style,
    output logic                         setup_conflict
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset state

    localparam fscr_pkg::fscr_state_t ST_RST = '{
        vscroll     : 10'h000,
        vscroll_upd : 1'b0,
        line_sp     : 5'h00,
        curx        : 10'h000,
        cury        : 9'h000,
        cursor_upd  : 1'b0,
        size        : fscr_pkg::FSCR_SZ16,
        gap         : 6'h00,
        height      : `FSCR_H16,
        row_pitch   : `FSCR_H16,
        col_pitch   : 7'h10,
        rom_type    : fscr_pkg::FSCR_ROM_T0,
        rom_type_ok : 1'b1,
        coding      : fscr_pkg::FSCR_CD_GB2312,
        style       : fscr_pkg::FSCR_ST_NORMAL,
        style_eff   : fscr_pkg::FSCR_ST_NORMAL,
        conflict    : 1'b0
    };

    ////////////////////////////////////////////////////////////////////////////
    // Signals

    fscr_pkg::fscr_state_t q;
    fscr_pkg::fscr_state_t d;
    logic                  reg_wr;
    logic                  reg_addr_ok;
    logic [5:0]            reg_idx;
    logic [7:0]            reg_wdata;
    logic [7:0]            reg_rdata;
    logic                  reg_hit;
    logic                  idx_known;

    ////////////////////////////////////////////////////////////////////////////
    // Bus port

    fscr_apb_port #(
        .ADDR_W      (ADDR_W)
    ) u_apb (
        .core_clk    (core_clk),
        .reset       (reset),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .pready      (pready),
        .prdata      (prdata),
        .pslverr     (pslverr),
        .reg_wr      (reg_wr),
        .reg_addr_ok (reg_addr_ok),
        .reg_idx     (reg_idx),
        .reg_wdata   (reg_wdata),
        .reg_rdata   (reg_rdata),
        .reg_hit     (reg_hit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Glyph height per size code

    function automatic logic [5:0] height_of(input fscr_pkg::fscr_size_t sz);
        logic [5:0] h;
        h = `FSCR_H32;
        unique case (sz)
            fscr_pkg::FSCR_SZ16:  h = `FSCR_H16;
            fscr_pkg::FSCR_SZ24:  h = `FSCR_H24;
            fscr_pkg::FSCR_SZ32A: h = `FSCR_H32;
            fscr_pkg::FSCR_SZ32B: h = `FSCR_H32;
        endcase
        return h;
    endfunction : height_of

    ////////////////////////////////////////////////////////////////////////////
    // Read mux, unused bits read as zero

    always_comb begin
        idx_known = 1'b1;
        reg_rdata = `FSCR_RST_BYTE;
        case (reg_idx)
            `FSCR_IDX_VSCR_LO: reg_rdata = q.vscroll[7:0];
            `FSCR_IDX_VSCR_HI: reg_rdata = {6'h00, q.vscroll[9:8]};
            `FSCR_IDX_LINE_SP: reg_rdata = {3'h0, q.line_sp};
            `FSCR_IDX_CURX_LO: reg_rdata = q.curx[7:0];
            `FSCR_IDX_CURX_HI: reg_rdata = {6'h00, q.curx[9:8]};
            `FSCR_IDX_CURY_LO: reg_rdata = q.cury[7:0];
            `FSCR_IDX_CURY_HI: reg_rdata = {7'h00, q.cury[8]};
            `FSCR_IDX_GLYPH:   reg_rdata = {q.size, q.gap};
            `FSCR_IDX_EXTROM:  reg_rdata = {q.rom_type, q.coding, q.style};
            default:           idx_known = 1'b0;
        endcase
    end

    assign reg_hit = reg_addr_ok & idx_known;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        d             = q;
        d.vscroll_upd = 1'b0;
        d.cursor_upd  = 1'b0;
        if (reg_wr) begin
            case (reg_idx)
                `FSCR_IDX_VSCR_LO: begin
                    d.vscroll[7:0] = reg_wdata;                        // [R1]
                    d.vscroll_upd  = 1'b1;                             // [R1]
                end
                `FSCR_IDX_VSCR_HI: begin
                    d.vscroll[9:8] = reg_wdata[1:0];                   // [R1]
                    d.vscroll_upd  = 1'b1;                             // [R1]
                end
                `FSCR_IDX_LINE_SP: begin
                    d.line_sp = reg_wdata[4:0];                        // [R2]
                end
                `FSCR_IDX_CURX_LO: begin
                    d.curx[7:0]  = reg_wdata;                          // [R3]
                    d.cursor_upd = 1'b1;                               // [R3]
                end
                `FSCR_IDX_CURX_HI: begin
                    d.curx[9:8]  = reg_wdata[1:0];                     // [R3]
                    d.cursor_upd = 1'b1;                               // [R3]
                end
                `FSCR_IDX_CURY_LO: begin
                    d.cury[7:0]  = reg_wdata;                          // [R4]
                    d.cursor_upd = 1'b1;                               // [R4]
                end
                `FSCR_IDX_CURY_HI: begin
                    d.cury[8]    = reg_wdata[0];                       // [R4]
                    d.cursor_upd = 1'b1;                               // [R4]
                end
                `FSCR_IDX_GLYPH: begin
                    d.size = fscr_pkg::fscr_size_t'(reg_wdata[`FSCR_SIZE_POS +: 2]);      // [R5]
                    d.gap  = reg_wdata[`FSCR_GAP_LSB +: 6];                              // [R6]
                end
                `FSCR_IDX_EXTROM: begin
                    d.rom_type = fscr_pkg::fscr_rom_type_t'(reg_wdata[`FSCR_ROMT_LSB +: 3]); // [R7]
                    d.coding   = fscr_pkg::fscr_coding_t'(reg_wdata[`FSCR_CODE_LSB +: 3]);   // [R8]
                    d.style    = fscr_pkg::fscr_style_t'(reg_wdata[`FSCR_STYLE_LSB +: 2]);   // [R9]
                end
                default: begin
                end
            endcase
        end

        // Derived glyph geometry
        d.height    = height_of(d.size);                               // [R5]
        d.row_pitch = d.height + {1'b0, d.line_sp};                    // [R2]
        d.col_pitch = {1'b0, d.height} + {1'b0, d.gap};                // [R6]

        // Font memory fetch controls
        d.rom_type_ok = (d.rom_type <= `FSCR_ROMT_MAX);                // [R7]
        if ((d.coding == fscr_pkg::FSCR_CD_ASCII) || (d.coding == fscr_pkg::FSCR_CD_LATIN)) begin
            d.style_eff = d.style;                                     // [R9]
        end else begin
            d.style_eff = fscr_pkg::FSCR_ST_NORMAL;                    // [R9]
        end

        // Host setup check per glyph source
        if (ext_glyph_rom_sel) begin
            d.conflict = (d.size != fscr_pkg::FSCR_SZ16);              // [R10]
        end else begin
            d.conflict = ({d.rom_type, d.coding, d.style} != `FSCR_RST_BYTE); // [R10]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge core_clk) begin
        if (reset) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign vscroll_offset    = q.vscroll;
    assign vscroll_update    = q.vscroll_upd;
    assign text_line_spacing = q.line_sp;
    assign text_cursor_x     = q.curx;
    assign text_cursor_y     = q.cury;
    assign cursor_update     = q.cursor_upd;
    assign glyph_size        = q.size;
    assign glyph_height      = q.height;
    assign char_gap          = q.gap;
    assign row_pitch         = q.row_pitch;
    assign col_pitch         = q.col_pitch;
    assign font_mem_type     = q.rom_type;
    assign font_mem_type_ok  = q.rom_type_ok;
    assign font_coding       = q.coding;
    assign font_style        = q.style_eff;
    assign setup_conflict    = q.conflict;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    scroll_low_a: assert property ( // [R1]
        reg_wr && reg_idx == `FSCR_IDX_VSCR_LO
        |=> vscroll_offset[7:0] == $past(reg_wdata) && vscroll_update ##1 !vscroll_update || reg_wr)
        else $error("scroll low byte not taken");

    scroll_high_a: assert property ( // [R1]
        reg_wr && reg_idx == `FSCR_IDX_VSCR_HI
        |=> vscroll_offset[9:8] == $past(reg_wdata[1:0]) && vscroll_offset[7:0] == $past(vscroll_offset[7:0]))
        else $error("scroll high bits not taken");

    row_pitch_a: assert property ( // [R2]
        row_pitch == glyph_height + {1'b0, text_line_spacing})
        else $error("row pitch wrong");

    cursor_x_a: assert property ( // [R3]
        reg_wr && reg_idx == `FSCR_IDX_CURX_HI
        |=> text_cursor_x[9:8] == $past(reg_wdata[1:0]) && cursor_update)
        else $error("cursor x high bits not taken");

    cursor_y_hold_a: assert property ( // [R4]
        !(reg_wr && (reg_idx == `FSCR_IDX_CURY_LO || reg_idx == `FSCR_IDX_CURY_HI))
        |=> $stable(text_cursor_y))
        else $error("cursor y changed without write");

    glyph_height_a: assert property ( // [R5]
        glyph_height == (glyph_size == fscr_pkg::FSCR_SZ16 ? `FSCR_H16 :
                         glyph_size == fscr_pkg::FSCR_SZ24 ? `FSCR_H24 : `FSCR_H32))
        else $error("glyph height does not match size");

    col_pitch_a: assert property ( // [R6]
        reg_wr && reg_idx == `FSCR_IDX_GLYPH
        |=> char_gap == $past(reg_wdata[5:0]) && col_pitch == {1'b0, glyph_height} + {1'b0, char_gap})
        else $error("character gap not applied");

    rom_type_a: assert property ( // [R7]
        font_mem_type_ok == (font_mem_type <= `FSCR_ROMT_MAX))
        else $error("font memory type check wrong");

    coding_hold_a: assert property ( // [R8]
        !(reg_wr && reg_idx == `FSCR_IDX_EXTROM) |=> $stable(font_coding))
        else $error("coding changed without write");

    style_gate_a: assert property ( // [R9]
        font_coding != fscr_pkg::FSCR_CD_ASCII && font_coding != fscr_pkg::FSCR_CD_LATIN
        |-> font_style == fscr_pkg::FSCR_ST_NORMAL)
        else $error("style applied to wrong coding");

    line_sp_a: assert property ( // [R2]
        reg_wr && reg_idx == `FSCR_IDX_LINE_SP
        |=> text_line_spacing == $past(reg_wdata[4:0]))
        else $error("line spacing not taken");

    cursor_x_low_a: assert property ( // [R3]
        reg_wr && reg_idx == `FSCR_IDX_CURX_LO
        |=> text_cursor_x[7:0] == $past(reg_wdata) && cursor_update)
        else $error("cursor x low byte not taken");

    cursor_pulse_a: assert property ( // [R3]
        cursor_update
        |-> $past(reg_wr) && $past(reg_idx) >= `FSCR_IDX_CURX_LO && $past(reg_idx) <= `FSCR_IDX_CURY_HI)
        else $error("cursor pulse without cursor write");

    cursor_y_a: assert property ( // [R4]
        reg_wr && reg_idx == `FSCR_IDX_CURY_HI
        |=> text_cursor_y[8] == $past(reg_wdata[0]) && cursor_update)
        else $error("cursor y high bit not taken");

    size_field_a: assert property ( // [R5]
        reg_wr && reg_idx == `FSCR_IDX_GLYPH
        |=> glyph_size == $past(reg_wdata[7:6]))
        else $error("size field not taken");

    setup_word_a: assert property ( // [R7]
        reg_wr && reg_idx == `FSCR_IDX_EXTROM
        |=> {font_mem_type, font_coding} == $past(reg_wdata[7:2]))
        else $error("font memory setup not taken");

    conflict_flag_a: assert property ( // [R10]
        ext_glyph_rom_sel |=> setup_conflict == (glyph_size != fscr_pkg::FSCR_SZ16))
        else $error("size conflict not reported");

    scroll_write_c: cover property (reg_wr && reg_idx == `FSCR_IDX_VSCR_HI ##1 vscroll_update);
    extrom_write_c: cover property (reg_wr && reg_idx == `FSCR_IDX_EXTROM ##1 font_style != fscr_pkg::FSCR_ST_NORMAL);
    unmapped_c:     cover property (pslverr);
    conflict_c:     cover property (setup_conflict);
    back_to_back_c: cover property (pready ##1 psel && !penable ##1 pready);

endmodule : fscr_regs

// ===== inc/fscr_cfg.svh
`ifndef FSCR_CFG_SVH
`define FSCR_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// Register indexes, byte address is four times the index
`define FSCR_IDX_VSCR_LO  6'h26
`define FSCR_IDX_VSCR_HI  6'h27
`define FSCR_IDX_LINE_SP  6'h29
`define FSCR_IDX_CURX_LO  6'h2A
`define FSCR_IDX_CURX_HI  6'h2B
`define FSCR_IDX_CURY_LO  6'h2C
`define FSCR_IDX_CURY_HI  6'h2D
`define FSCR_IDX_GLYPH    6'h2E
`define FSCR_IDX_EXTROM   6'h2F

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define FSCR_RST_BYTE     8'h00

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define FSCR_SIZE_LSB     3
`define FSCR_SIZE_POS     6
`define FSCR_GAP_LSB      0
`define FSCR_ROMT_LSB     5
`define FSCR_CODE_LSB     2
`define FSCR_STYLE_LSB    0

////////////////////////////////////////////////////////////////////////////////
// Glyph heights in pixels and last legal font memory type
`define FSCR_H16          6'h10
`define FSCR_H24          6'h18
`define FSCR_H32          6'h20
`define FSCR_ROMT_MAX     3'h4

`endif

// ===== inc/fscr_pkg.sv
package fscr_pkg;

    typedef enum logic [1:0] {
        FSCR_SZ16  = 2'h0,
        FSCR_SZ24  = 2'h1,
        FSCR_SZ32A = 2'h2,
        FSCR_SZ32B = 2'h3
    } fscr_size_t;

    typedef enum logic [2:0] {
        FSCR_ROM_T0 = 3'h0,
        FSCR_ROM_T1 = 3'h1,
        FSCR_ROM_T2 = 3'h2,
        FSCR_ROM_T3 = 3'h3,
        FSCR_ROM_T4 = 3'h4,
        FSCR_ROM_X5 = 3'h5,
        FSCR_ROM_X6 = 3'h6,
        FSCR_ROM_X7 = 3'h7
    } fscr_rom_type_t;

    typedef enum logic [2:0] {
        FSCR_CD_GB2312  = 3'h0,
        FSCR_CD_GB18030 = 3'h1,
        FSCR_CD_BIG5    = 3'h2,
        FSCR_CD_UNICODE = 3'h3,
        FSCR_CD_ASCII   = 3'h4,
        FSCR_CD_UNI_JP  = 3'h5,
        FSCR_CD_JIS0208 = 3'h6,
        FSCR_CD_LATIN   = 3'h7
    } fscr_coding_t;

    typedef enum logic [1:0] {
        FSCR_ST_NORMAL = 2'h0,
        FSCR_ST_SANS   = 2'h1,
        FSCR_ST_ROMAN  = 2'h2,
        FSCR_ST_BOLD   = 2'h3
    } fscr_style_t;

    typedef struct packed {
        logic [9:0]     vscroll;
        logic           vscroll_upd;
        logic [4:0]     line_sp;
        logic [9:0]     curx;
        logic [8:0]     cury;
        logic           cursor_upd;
        fscr_size_t     size;
        logic [5:0]     gap;
        logic [5:0]     height;
        logic [5:0]     row_pitch;
        logic [6:0]     col_pitch;
        fscr_rom_type_t rom_type;
        logic           rom_type_ok;
        fscr_coding_t   coding;
        fscr_style_t    style;
        fscr_style_t    style_eff;
        logic           conflict;
    } fscr_state_t;

    typedef struct packed {
        logic [31:0] prdata;
    } fscr_apb_state_t;

endpackage : fscr_pkg

// ===== sim/fscr_host.sv
`timescale 1ns/10ps

module fscr_host (
    // Clock
    input  wire logic        core_clk,
    // APB master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h00000000;
    end

    ////////////////////////////////////////
    // One transfer, held until pready
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d, input logic hold,
                        output logic [31:0] r, output logic e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        if (!hold) begin
            psel    <= 1'b0;
            penable <= 1'b0;
            pwdata  <= ~pwdata;
        end
    endtask : xfer
endmodule : fscr_host

// ===== sim/tb.sv
`timescale 1ns/10ps
`include "fscr_cfg.svh"
`define FSCR_CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin num_errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end

module tb;
    typedef struct { logic [5:0] idx; logic [7:0] wd; logic [7:0] rd; } fscr_row_t;

    logic                     core_clk, reset, ext_glyph_rom_sel;
    logic                     psel, penable, pwrite, pready, pslverr;
    logic [11:0]              paddr;
    logic [31:0]              pwdata, prdata;
    logic [9:0]               vscroll_offset, text_cursor_x;
    logic                     vscroll_update, cursor_update, font_mem_type_ok, setup_conflict;
    logic [4:0]               text_line_spacing;
    logic [8:0]               text_cursor_y;
    fscr_pkg::fscr_size_t     glyph_size;
    logic [5:0]               glyph_height, char_gap, row_pitch;
    logic [6:0]               col_pitch;
    fscr_pkg::fscr_rom_type_t font_mem_type;
    fscr_pkg::fscr_coding_t   font_coding;
    fscr_pkg::fscr_style_t    font_style;
    int                       num_errors, checked;
    logic [31:0]              r;
    logic                     e;
    logic [5:0]               h;
    fscr_row_t rows[9] = '{'{`FSCR_IDX_VSCR_LO, 8'hFF, 8'hFF}, '{`FSCR_IDX_VSCR_HI, 8'hFF, 8'h03},
        '{`FSCR_IDX_LINE_SP, 8'hFF, 8'h1F}, '{`FSCR_IDX_CURX_LO, 8'hA5, 8'hA5},
        '{`FSCR_IDX_CURX_HI, 8'hFF, 8'h03}, '{`FSCR_IDX_CURY_LO, 8'h5A, 8'h5A},
        '{`FSCR_IDX_CURY_HI, 8'hFF, 8'h01}, '{`FSCR_IDX_GLYPH, 8'h4A, 8'h4A},
        '{`FSCR_IDX_EXTROM, 8'h9F, 8'h9F}};

    always #2.5 core_clk = ~core_clk;

    fscr_regs u_dut (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .ext_glyph_rom_sel(ext_glyph_rom_sel), .vscroll_offset(vscroll_offset),
        .vscroll_update(vscroll_update), .text_line_spacing(text_line_spacing),
        .text_cursor_x(text_cursor_x), .text_cursor_y(text_cursor_y), .cursor_update(cursor_update),
        .glyph_size(glyph_size), .glyph_height(glyph_height), .char_gap(char_gap), .row_pitch(row_pitch),
        .col_pitch(col_pitch), .font_mem_type(font_mem_type), .font_mem_type_ok(font_mem_type_ok),
        .font_coding(font_coding), .font_style(font_style), .setup_conflict(setup_conflict));

    fscr_host u_host (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

    ////////////////////////////////////////
    // Bus access with response check
    task automatic acc(input logic w, input logic [5:0] idx, input logic [7:0] d, input logic [7:0] ex);
        @(posedge core_clk);
        u_host.xfer(w, {4'h0, idx, 2'b00}, d, 1'b0, r, e);
        `FSCR_CHK("pslverr", 1'b0, e)
        if (!w) `FSCR_CHK("prdata", {24'h000000, ex}, r)
        #1;
    endtask : acc

    task automatic close_out;
        $display("Checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    initial begin
        #60000;
        num_errors++;
        close_out;
    end

    ////////////////////////////////////////
    // Main sequence
    initial begin
        core_clk          = 1'b0;
        reset             = 1'b1;
        ext_glyph_rom_sel = 1'b0;
        num_errors        = 0;
        checked           = 0;
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        #1;
        `FSCR_CHK("glyph_height", 6'h10, glyph_height)
        `FSCR_CHK("col_pitch", 7'h10, col_pitch)
        `FSCR_CHK("type_ok", 1'b1, font_mem_type_ok)
        foreach (rows[i]) begin
            acc(1'b0, rows[i].idx, 8'h00, 8'h00);
            acc(1'b1, rows[i].idx, rows[i].wd, 8'h00);
            acc(1'b0, rows[i].idx, 8'h00, rows[i].rd);
        end
        `FSCR_CHK("vscroll", 10'h3FF, vscroll_offset)
        `FSCR_CHK("line_sp", 5'h1F, text_line_spacing)
        `FSCR_CHK("row_pitch", 6'h37, row_pitch)
        `FSCR_CHK("cur_x", 10'h3A5, text_cursor_x)
        `FSCR_CHK("cur_y", 9'h15A, text_cursor_y)
        `FSCR_CHK("size", fscr_pkg::FSCR_SZ24, glyph_size)
        `FSCR_CHK("gap", 6'h0A, char_gap)
        `FSCR_CHK("col_pitch", 7'h22, col_pitch)
        `FSCR_CHK("type", fscr_pkg::FSCR_ROM_T4, font_mem_type)
        `FSCR_CHK("style", fscr_pkg::FSCR_ST_BOLD, font_style)
        `FSCR_CHK("conflict", 1'b1, setup_conflict)
        // Per-byte update and one-cycle pulses
        acc(1'b1, `FSCR_IDX_VSCR_LO, 8'h12, 8'h00);
        `FSCR_CHK("vscroll", 10'h312, vscroll_offset)
        `FSCR_CHK("vs_upd", 1'b1, vscroll_update)
        @(posedge core_clk);
        #1;
        `FSCR_CHK("vs_upd_end", 1'b0, vscroll_update)
        acc(1'b1, `FSCR_IDX_CURY_HI, 8'h00, 8'h00);
        `FSCR_CHK("cur_y", 9'h05A, text_cursor_y)
        `FSCR_CHK("cur_upd", 1'b1, cursor_update)
        // Every size code at the widest gap
        for (int s = 0; s < 4; s++) begin
            h = s[1] ? 6'h20 : (s[0] ? 6'h18 : 6'h10);
            acc(1'b1, `FSCR_IDX_GLYPH, {s[1:0], 6'h3F}, 8'h00);
            `FSCR_CHK("height", h, glyph_height)
            `FSCR_CHK("col_pitch", {1'b0, h} + 7'h3F, col_pitch)
            `FSCR_CHK("row_pitch", h + 6'h1F, row_pitch)
        end
        // Every memory type and coding, style bold
        for (int i = 0; i < 8; i++) begin
            acc(1'b1, `FSCR_IDX_EXTROM, {i[2:0], i[2:0], 2'b11}, 8'h00);
            `FSCR_CHK("type_ok", (i <= 4), font_mem_type_ok)
            `FSCR_CHK("coding", i[2:0], font_coding)
            `FSCR_CHK("style", (i == 4 || i == 7) ? 2'h3 : 2'h0, font_style)
        end
        // Unmapped, misaligned and out of range
        foreach (rows[i]) begin
            @(posedge core_clk);
            u_host.xfer(i[0], (i < 3) ? 12'h0A0 : ((i < 6) ? 12'h099 : 12'h198), 8'h55, 1'b0, r, e);
            `FSCR_CHK("refused", 1'b1, e)
            `FSCR_CHK("refused_rd", 32'h00000000, r)
        end
        `FSCR_CHK("vscroll", 10'h312, vscroll_offset)
        acc(1'b0, `FSCR_IDX_EXTROM, 8'h00, 8'hFF);
        // Glyph source against setup values
        @(posedge core_clk);
        ext_glyph_rom_sel <= 1'b1;
        acc(1'b1, `FSCR_IDX_GLYPH, 8'h00, 8'h00);
        `FSCR_CHK("conflict", 1'b0, setup_conflict)
        acc(1'b1, `FSCR_IDX_GLYPH, 8'h40, 8'h00);
        `FSCR_CHK("conflict", 1'b1, setup_conflict)
        @(posedge core_clk);
        ext_glyph_rom_sel <= 1'b0;
        acc(1'b1, `FSCR_IDX_EXTROM, 8'h00, 8'h00);
        `FSCR_CHK("conflict", 1'b0, setup_conflict)
        // Back-to-back writes
        @(posedge core_clk);
        u_host.xfer(1'b1, {4'h0, `FSCR_IDX_CURX_LO, 2'b00}, 8'h11, 1'b1, r, e);
        u_host.xfer(1'b1, {4'h0, `FSCR_IDX_CURX_HI, 2'b00}, 8'h02, 1'b0, r, e);
        #1;
        `FSCR_CHK("cur_x", 10'h211, text_cursor_x)
        `FSCR_CHK("cur_upd", 1'b1, cursor_update)
        // Reset in mid-run
        @(posedge core_clk);
        reset <= 1'b1;
        @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        #1;
        `FSCR_CHK("vscroll", 10'h000, vscroll_offset)
        `FSCR_CHK("cur_x", 10'h000, text_cursor_x)
        `FSCR_CHK("height", 6'h10, glyph_height)
        acc(1'b0, `FSCR_IDX_LINE_SP, 8'h00, 8'h00);
        close_out;
    end
endmodule : tb
